// ---- hdl/cffs_defines.svh ----
// register offsets, field positions, reset values and scale constants
`ifndef CFFS_DEFINES_SVH
`define CFFS_DEFINES_SVH
`define CFFS_IDX_SUBMODE   16'h3202
`define CFFS_IDX_FBMASK    16'h3203
`define CFFS_IDX_ACCREF    16'h320d
`define CFFS_IDX_FFFACT    16'h321d
`define CFFS_IDX_STATUS    16'h6041
`define CFFS_IDX_BLKSTAT   16'h3f00
`define CFFS_SUB_VOLT      8'h01
`define CFFS_SUB_ACCEL     8'h02
`define CFFS_SUB_VEL       8'h03
`define CFFS_SUB_FIRSTMASK 8'h01
`define CFFS_NSENS         4
`define CFFS_SM_CLOSED     0
`define CFFS_SM_VELPOS     1
`define CFFS_SM_AUTOALIGN  4
`define CFFS_FB_POS        0
`define CFFS_FB_VEL        1
`define CFFS_FB_COMM       2
`define CFFS_SW_CLACTIVE   15
`define CFFS_PERMILLE      16'h03e8
`define CFFS_RST_VOLTFF    16'h03e8
`define CFFS_RST_ACCFF     16'h0000
`define CFFS_RST_VELFF     16'h0000
`define CFFS_RST_ACCREF    16'h03e8
`define CFFS_RST_SUBMODE   16'h0000
`define CFFS_RST_MASK      8'h00
`define CFFS_SW_OPEN       16'h0027
`define CFFS_SW_DISABLED   16'h0040
`endif

// ---- hdl/cffs_pkg.sv ----
// types shared by the feed-forward and feedback select block
package cffs_pkg;
   typedef enum logic [3:0] {
      CFFS_PROF_POS, CFFS_HOMING, CFFS_INTERP_POS, CFFS_CYC_POS, CFFS_CLK_DIR,
      CFFS_VELOCITY, CFFS_PROF_VEL, CFFS_CYC_VEL, CFFS_PROF_TORQUE, CFFS_CYC_TORQUE
   } cffs_mode_t;
   typedef struct packed {
      logic signed [31:0] ramp_velocity_output;
      logic signed [31:0] ramp_accel_output;
      logic signed [31:0] pos_ctrl_out;
      logic signed [31:0] vel_ctrl_out;
      logic        [15:0] rated_voltage;
   } cffs_loop_in_t;
   typedef struct packed {
      logic signed [31:0] vel_setpoint;
      logic signed [31:0] cur_setpoint;
      logic signed [31:0] volt_feed_forward;
   } cffs_loop_out_t;
   typedef struct packed {
      logic [1:0] pos_sel;
      logic [1:0] vel_sel;
      logic [1:0] comm_sel;
   } cffs_fb_sel_t;
   typedef enum logic [1:0] {CFFS_ST_OFF, CFFS_ST_ALIGN, CFFS_ST_ON} cffs_state_t;
endpackage

// ---- hdl/cffs_top.sv ----
// feed-forward injection, feedback selection and closed-loop activation
// Notes on behaviour
// - velocity ff: ramp velocity times per-mille factor added to position controller output
// - velocity ff only in position-loop modes, velocity and profile velocity modes when submode bit 1 set
// - accel ff: per-mille of reference factor times ramp accel, added after velocity loop
// - accel ff added in every mode except torque modes
// - voltage ff is per-mille of rated-current voltage, factor resets to 1000
// - voltage ff active in all modes, off when its factor is zero
// - mask bit 0 position, bit 1 velocity, bit 2 commutation
// - first mask entry is the sensorless feedback, others follow sensor order
// - each controller scans from sensor 2 upward, first set bit wins
// - before encoder index, Hall commutates and closed loop runs at once
// - with two commutation sensors, use whichever currently has alignment
// - no aligned commutation sensor: align in open loop regardless of bit 4
// - closed loop needs submode bit 0; auto setup completion sets it
// - absolute commutation sensor gives closed loop right from power-up
// - encoder commutation stays open loop until index seen once or alignment completed
// - submode bit 4: auto alignment once per restart at first enable command
// - alignment moves rotor to a pole before Operation enabled and travel resume
// - status bit 15 shows closed loop active while Operation enabled
//
// Added by the designer: the strobed register port.
`include "cffs_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module cffs_top
   import cffs_pkg::*;
(
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rstn_i,
   // register port
   input  wire logic [23:0]     reg_addr_i,
   input  wire logic [15:0]     reg_wdata_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   output logic      [15:0]     reg_rdata_o,
   // control loop values
   input  wire cffs_mode_t      op_mode_i,
   input  wire cffs_loop_in_t   loop_i,
   output cffs_loop_out_t       loop_o,
   output cffs_fb_sel_t         fb_sel_o,
   // sensors and sequencing
   input  wire logic [3:0]      sensor_abs_i,
   input  wire logic            enc_index_i,
   input  wire logic            autosetup_done_i,
   input  wire logic            enable_req_i,
   input  wire logic            brake_ctrl_off_i,
   input  wire logic            align_reached_i,
   output logic                 align_move_o,
   output logic                 travel_hold_o,
   output logic                 op_enabled_o,
   output logic                 closed_loop_o,
   output logic      [15:0]     status_word_o
);

   function automatic logic signed [31:0] permille(input logic signed [31:0] v, input logic [15:0] f);
      logic signed [48:0] p;
      p = 49'(v) * $signed({33'h0, f});
      permille = 32'(p / $signed({33'h0, `CFFS_PERMILLE}));
   endfunction

   function automatic logic [2:0] scan(input logic [3:0] hits);
      scan = 3'h0;
      for (int i = `CFFS_NSENS - 1; i >= 1; i--) begin
         if (hits[i]) begin
            scan = {1'b1, 2'(i)};
         end
      end
   endfunction

   // registers
   logic [7:0]  mask_reg [`CFFS_NSENS];
   logic [7:0]  mask_next [`CFFS_NSENS];
   logic [15:0] voltff_reg, voltff_next;
   logic [15:0] accff_reg, accff_next;
   logic [15:0] velff_reg, velff_next;
   logic [15:0] accref_reg, accref_next;
   logic [15:0] submode_reg, submode_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [15:0] addr_idx;
   logic [7:0]  addr_sub;
   logic        sub_is_mask;

   assign addr_idx = reg_addr_i[23:8];
   assign addr_sub = reg_addr_i[7:0];
   assign sub_is_mask = addr_sub >= `CFFS_SUB_FIRSTMASK && addr_sub < 8'(`CFFS_NSENS + 1);

   always_comb begin
      for (int i = 0; i < `CFFS_NSENS; i++) begin
         mask_next[i] = mask_reg[i];
      end
      voltff_next  = voltff_reg;
      accff_next   = accff_reg;
      velff_next   = velff_reg;
      accref_next  = accref_reg;
      submode_next = submode_reg;
      if (reg_wr_i) begin
         case (addr_idx)
            `CFFS_IDX_FBMASK: begin
               if (sub_is_mask) begin
                  mask_next[2'(addr_sub - `CFFS_SUB_FIRSTMASK)] = reg_wdata_i[7:0];
               end
            end
            `CFFS_IDX_FFFACT: begin
               if (addr_sub == `CFFS_SUB_VOLT) voltff_next = reg_wdata_i;
               if (addr_sub == `CFFS_SUB_ACCEL) accff_next = reg_wdata_i;
               if (addr_sub == `CFFS_SUB_VEL) velff_next = reg_wdata_i;
            end
            `CFFS_IDX_ACCREF: accref_next = reg_wdata_i;
            `CFFS_IDX_SUBMODE: submode_next = reg_wdata_i;
            default: ;
         endcase
      end
      if (autosetup_done_i) begin
         submode_next[`CFFS_SM_CLOSED] = 1'b1;
      end
   end

   // status and read data
   logic [15:0] blkstat;
   always_comb begin
      rdata_next = 16'h0000;
      if (reg_rd_i) begin
         case (addr_idx)
            `CFFS_IDX_FBMASK: rdata_next = sub_is_mask ?
                  {8'h00, mask_reg[2'(addr_sub - `CFFS_SUB_FIRSTMASK)]} : 16'h0000;
            `CFFS_IDX_FFFACT: begin
               if (addr_sub == `CFFS_SUB_VOLT) rdata_next = voltff_reg;
               if (addr_sub == `CFFS_SUB_ACCEL) rdata_next = accff_reg;
               if (addr_sub == `CFFS_SUB_VEL) rdata_next = velff_reg;
            end
            `CFFS_IDX_ACCREF: rdata_next = accref_reg;
            `CFFS_IDX_SUBMODE: rdata_next = submode_reg;
            `CFFS_IDX_STATUS: rdata_next = status_word_o;
            `CFFS_IDX_BLKSTAT: rdata_next = blkstat;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < `CFFS_NSENS; i++) begin
            mask_reg[i] <= `CFFS_RST_MASK;
         end
         voltff_reg  <= `CFFS_RST_VOLTFF;
         accff_reg   <= `CFFS_RST_ACCFF;
         velff_reg   <= `CFFS_RST_VELFF;
         accref_reg  <= `CFFS_RST_ACCREF;
         submode_reg <= `CFFS_RST_SUBMODE;
         rdata_reg   <= 16'h0000;
      end else begin
         for (int i = 0; i < `CFFS_NSENS; i++) begin
            mask_reg[i] <= mask_next[i];
         end
         voltff_reg  <= voltff_next;
         accff_reg   <= accff_next;
         velff_reg   <= velff_next;
         accref_reg  <= accref_next;
         submode_reg <= submode_next;
         rdata_reg   <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // encoder index pin: three-stage synchroniser and agreement filter
   logic [2:0] idx_sync_reg, idx_sync_next;
   logic       idx_filt_reg, idx_filt_next;
   logic       idx_seen_reg, idx_seen_next;
   always_comb begin
      idx_sync_next = {idx_sync_reg[1:0], enc_index_i};
      idx_filt_next = (idx_sync_reg[1] == idx_sync_reg[2]) ? idx_sync_reg[2] : idx_filt_reg;
      idx_seen_next = idx_seen_reg | (idx_filt_next & ~idx_filt_reg);
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idx_sync_reg <= 3'h0;
         idx_filt_reg <= 1'b0;
         idx_seen_reg <= 1'b0;
      end else begin
         idx_sync_reg <= idx_sync_next;
         idx_filt_reg <= idx_filt_next;
         idx_seen_reg <= idx_seen_next;
      end
   end

   // feedback selection and alignment
   logic [3:0]  pos_hits, vel_hits, comm_hits, align_ok;
   logic [2:0]  pos_pick, vel_pick, comm_pick, comm_any;
   logic        align_done_reg, align_done_next;
   logic        align_ran_reg, align_ran_next;
   logic        cl_active;
   always_comb begin
      for (int i = 0; i < `CFFS_NSENS; i++) begin
         pos_hits[i]  = mask_reg[i][`CFFS_FB_POS];
         vel_hits[i]  = mask_reg[i][`CFFS_FB_VEL];
         comm_hits[i] = mask_reg[i][`CFFS_FB_COMM];
         align_ok[i]  = sensor_abs_i[i] | idx_seen_reg | align_done_reg;
      end
   end
   assign pos_pick  = scan(pos_hits);
   assign vel_pick  = scan(vel_hits);
   assign comm_any  = scan(comm_hits);
   assign comm_pick = scan(comm_hits & align_ok);
   assign cl_active = submode_reg[`CFFS_SM_CLOSED] & comm_pick[2];

   // enable sequencing with auto alignment
   cffs_state_t state_reg, state_next;
   logic        need_align;
   assign need_align = submode_reg[`CFFS_SM_AUTOALIGN] | ~comm_pick[2];
   always_comb begin
      state_next      = state_reg;
      align_done_next = align_done_reg;
      align_ran_next  = align_ran_reg;
      case (state_reg)
         CFFS_ST_OFF: begin
            if (enable_req_i) begin
               if (need_align && !align_ran_reg) begin
                  state_next     = CFFS_ST_ALIGN;
                  align_ran_next = 1'b1;
               end else begin
                  state_next = CFFS_ST_ON;
               end
            end
         end
         CFFS_ST_ALIGN: begin
            if (!enable_req_i) begin
               state_next = CFFS_ST_OFF;
            end else if (brake_ctrl_off_i && align_reached_i) begin
               state_next      = CFFS_ST_ON;
               align_done_next = 1'b1;
            end
         end
         CFFS_ST_ON: begin
            if (!enable_req_i) state_next = CFFS_ST_OFF;
         end
         default: state_next = CFFS_ST_OFF;
      endcase
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg      <= CFFS_ST_OFF;
         align_done_reg <= 1'b0;
         align_ran_reg  <= 1'b0;
      end else begin
         state_reg      <= state_next;
         align_done_reg <= align_done_next;
         align_ran_reg  <= align_ran_next;
      end
   end
   assign align_move_o  = (state_reg == CFFS_ST_ALIGN) & brake_ctrl_off_i;
   assign travel_hold_o = (state_reg != CFFS_ST_ON);
   assign op_enabled_o  = (state_reg == CFFS_ST_ON);
   assign closed_loop_o = cl_active;
   assign status_word_o = op_enabled_o ? (`CFFS_SW_OPEN | {cl_active, 15'h0000}) : `CFFS_SW_DISABLED;
   assign blkstat = {7'h00, align_done_reg, idx_seen_reg, comm_any[2], comm_pick[1:0], state_reg, 2'h0};

   // feed-forward datapath
   logic           pos_loop, torque_mode;
   logic signed [31:0] acc_scale;
   cffs_loop_out_t out_reg, out_next;
   cffs_fb_sel_t   sel_reg, sel_next;
   always_comb begin
      case (op_mode_i)
         CFFS_PROF_POS, CFFS_HOMING, CFFS_INTERP_POS, CFFS_CYC_POS, CFFS_CLK_DIR: pos_loop = 1'b1;
         CFFS_VELOCITY, CFFS_PROF_VEL: pos_loop = submode_reg[`CFFS_SM_VELPOS];
         default: pos_loop = 1'b0;
      endcase
      torque_mode = (op_mode_i == CFFS_PROF_TORQUE) || (op_mode_i == CFFS_CYC_TORQUE);
      out_next.vel_setpoint = loop_i.pos_ctrl_out;
      if (pos_loop) begin
         out_next.vel_setpoint = loop_i.pos_ctrl_out + permille(loop_i.ramp_velocity_output, velff_reg);
      end
      acc_scale = permille({16'h0000, accref_reg}, accff_reg);
      out_next.cur_setpoint = loop_i.vel_ctrl_out;
      if (!torque_mode) begin
         out_next.cur_setpoint = loop_i.vel_ctrl_out +
            permille(loop_i.ramp_accel_output, acc_scale[15:0]);
      end
      out_next.volt_feed_forward = permille({16'h0000, loop_i.rated_voltage}, voltff_reg);
      sel_next.pos_sel  = pos_pick[1:0];
      sel_next.vel_sel  = vel_pick[1:0];
      sel_next.comm_sel = comm_pick[1:0];
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_reg <= '0;
         sel_reg <= '0;
      end else begin
         out_reg <= out_next;
         sel_reg <= sel_next;
      end
   end
   assign loop_o   = out_reg;
   assign fb_sel_o = sel_reg;

   // checks
   a_vff_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (op_mode_i == CFFS_CYC_VEL) |=> loop_o.vel_setpoint == $past(loop_i.pos_ctrl_out))
      else $error("velocity ff added outside position loop");
   a_aff_torque: assert property (@(posedge clk_i) disable iff (!rstn_i)
      torque_mode |=> loop_o.cur_setpoint == $past(loop_i.vel_ctrl_out))
      else $error("accel ff added in torque mode");
   a_volt_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (voltff_reg == 16'h0000) |=> loop_o.volt_feed_forward == 32'sh0)
      else $error("voltage ff not off at zero factor");
   a_status_cl: assert property (@(posedge clk_i) disable iff (!rstn_i)
      op_enabled_o |-> status_word_o[`CFFS_SW_CLACTIVE] == closed_loop_o)
      else $error("status bit 15 wrong");
   a_setup_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
      autosetup_done_i |=> submode_reg[`CFFS_SM_CLOSED])
      else $error("auto setup did not set closed loop bit");
   a_cl_needs: assert property (@(posedge clk_i) disable iff (!rstn_i)
      closed_loop_o |-> submode_reg[`CFFS_SM_CLOSED])
      else $error("closed loop without bit 0");
   a_align_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state_reg == CFFS_ST_ALIGN) |-> !op_enabled_o && travel_hold_o)
      else $error("enabled during alignment");
   a_align_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
      align_ran_reg && state_reg == CFFS_ST_OFF |=> state_reg != CFFS_ST_ALIGN)
      else $error("alignment ran twice");
   a_index_open: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ((comm_hits & sensor_abs_i) == 4'h0 && !idx_seen_reg && !align_done_reg) |-> !closed_loop_o)
      else $error("closed loop before index");
   a_pos_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
      mask_reg[1][`CFFS_FB_POS] |=> fb_sel_o.pos_sel == 2'h1)
      else $error("sensor 2 not preferred for position");

endmodule
`default_nettype wire

// ---- testbench/cffs_motor_model.sv ----
// behavioural motor with hall sensors and an incremental encoder
`timescale 1ns/100ps
`default_nettype none
module cffs_motor_model #(
   parameter int ALIGN_CYCLES = 5,
   parameter int ENC_COUNTS   = 500,
   parameter int POLE_PAIRS   = 50
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // drive from device and bench
   input  wire logic       align_move_i,
   input  wire logic       index_cmd_i,
   // sensor outputs
   output logic      [3:0] sensor_abs_o,
   output logic            enc_index_o,
   output logic            align_reached_o
);
   int move_cnt;
   int idx_cnt;
   // hall on sensor 2 is absolute, encoder on sensor 3 is not
   assign sensor_abs_o = 4'h2;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         move_cnt <= 0;
         idx_cnt <= 0;
         enc_index_o <= 1'b0;
         align_reached_o <= 1'b0;
      end else begin
         // index mark held long enough to pass the input filter
         idx_cnt <= index_cmd_i ? 6 : (idx_cnt > 0 ? idx_cnt - 1 : 0);
         enc_index_o <= (idx_cnt > 0);
         // rotor reaches a pole some cycles after the move starts
         move_cnt <= align_move_i ? move_cnt + 1 : 0;
         align_reached_o <= align_move_i && (move_cnt >= ALIGN_CYCLES - 1);
      end
   end
endmodule
`default_nettype wire

// ---- testbench/cffs_top_test.sv ----
// self-checking bench for the feed-forward and feedback select block
`include "cffs_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module cffs_top_test;
   import cffs_pkg::*;
   typedef struct {
      cffs_mode_t         mode;
      logic        [15:0] sub;
      logic        [15:0] velff;
      logic        [15:0] voltff;
      logic signed [31:0] ev;
      logic signed [31:0] ec;
      logic signed [31:0] ew;
   } cffs_row_t;
   logic clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, enc_index_i, align_reached_i;
   logic [23:0] reg_addr_i = 24'h0;
   logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o, status_word_o;
   cffs_mode_t op_mode_i = CFFS_PROF_POS;
   cffs_loop_in_t loop_i = '{32'sd2000, 32'sd3000, 32'sd100, 32'sd50, 16'd400};
   cffs_loop_out_t loop_o;
   cffs_fb_sel_t fb_sel_o;
   logic [3:0] sensor_abs_i;
   logic autosetup_done_i = 1'b0, enable_req_i = 1'b0, brake_ctrl_off_i = 1'b0, index_cmd = 1'b0;
   logic align_move_o, travel_hold_o, op_enabled_o, closed_loop_o;
   int miscompares = 0, n_tests = 0, cycles = 0, k;
   cffs_row_t rows [11] = '{
      '{CFFS_PROF_POS,    16'h0, 16'd250, 16'd1000, 600, 1550, 400},
      '{CFFS_HOMING,      16'h0, 16'd250, 16'd500,  600, 1550, 200},
      '{CFFS_INTERP_POS,  16'h0, 16'd250, 16'd0,    600, 1550, 0},
      '{CFFS_CYC_POS,     16'h0, 16'd250, 16'd1000, 600, 1550, 400},
      '{CFFS_CLK_DIR,     16'h0, 16'd250, 16'd1000, 600, 1550, 400},
      '{CFFS_VELOCITY,    16'h0, 16'd250, 16'd1000, 100, 1550, 400},
      '{CFFS_VELOCITY,    16'h2, 16'd250, 16'd1000, 600, 1550, 400},
      '{CFFS_PROF_VEL,    16'h2, 16'd250, 16'd1000, 600, 1550, 400},
      '{CFFS_PROF_VEL,    16'h0, 16'd250, 16'd1000, 100, 1550, 400},
      '{CFFS_PROF_TORQUE, 16'h0, 16'd250, 16'd1000, 100, 50,   400},
      '{CFFS_CYC_TORQUE,  16'h0, 16'd0,   16'd1000, 100, 50,   400}};

   always #20 clk_i = ~clk_i;
   cffs_top cffs_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_mode_i(op_mode_i), .loop_i(loop_i),
      .loop_o(loop_o), .fb_sel_o(fb_sel_o), .sensor_abs_i(sensor_abs_i), .enc_index_i(enc_index_i),
      .autosetup_done_i(autosetup_done_i), .enable_req_i(enable_req_i), .brake_ctrl_off_i(brake_ctrl_off_i),
      .align_reached_i(align_reached_i), .align_move_o(align_move_o), .travel_hold_o(travel_hold_o),
      .op_enabled_o(op_enabled_o), .closed_loop_o(closed_loop_o), .status_word_o(status_word_o));
   cffs_motor_model cffs_motor_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .align_move_i(align_move_o),
      .index_cmd_i(index_cmd), .sensor_abs_o(sensor_abs_i), .enc_index_o(enc_index_i),
      .align_reached_o(align_reached_i));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string name);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk(name, {16'h0, reg_rdata_o}, {16'h0, exp});
   endtask
   task automatic do_reset();
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      do_reset();
      rd(24'h321d01, 16'h03e8, "volt ff factor");
      rd(24'h321d02, 16'h0000, "accel ff factor");
      rd(24'h321d03, 16'h0000, "vel ff factor");
      rd(24'h320d00, 16'h03e8, "accel reference");
      rd(24'h320200, 16'h0000, "submode");
      rd(24'h320302, 16'h0000, "mask 2");
      rd(24'h604100, 16'h0040, "status word");
      rd(24'h123400, 16'h0000, "unmapped");
      wr(24'h604100, 16'hffff);
      rd(24'h604100, 16'h0040, "status after write");
      $display("test registers done");
      wr(24'h321d02, 16'd500);
      foreach (rows[i]) begin
         wr(24'h320200, rows[i].sub);
         wr(24'h321d03, rows[i].velff);
         wr(24'h321d01, rows[i].voltff);
         op_mode_i <= rows[i].mode;
         wait_cyc(2);
         chk("vel setpoint", loop_o.vel_setpoint, rows[i].ev);
         chk("cur setpoint", loop_o.cur_setpoint, rows[i].ec);
         chk("volt ff", loop_o.volt_feed_forward, rows[i].ew);
      end
      $display("test feed forward done");
      wr(24'h320200, 16'h0000);
      wr(24'h320301, 16'h0007);
      wr(24'h320302, 16'h0006);
      wr(24'h320303, 16'h0007);
      @(posedge clk_i);
      autosetup_done_i <= 1'b1;
      @(posedge clk_i);
      autosetup_done_i <= 1'b0;
      rd(24'h320200, 16'h0001, "submode after setup");
      wait_cyc(2);
      chk("pos sel", fb_sel_o.pos_sel, 32'd2);
      chk("vel sel", fb_sel_o.vel_sel, 32'd1);
      chk("comm sel", fb_sel_o.comm_sel, 32'd1);
      chk("closed loop hall", closed_loop_o, 32'd1);
      wr(24'h320302, 16'h0002);
      wait_cyc(2);
      chk("closed loop no index", closed_loop_o, 32'd0);
      enable_req_i <= 1'b1;
      wait_cyc(3);
      chk("move with brake", align_move_o, 32'd0);
      chk("enabled early", op_enabled_o, 32'd0);
      chk("travel held", travel_hold_o, 32'd1);
      brake_ctrl_off_i <= 1'b1;
      wait_cyc(1);
      chk("align move", align_move_o, 32'd1);
      for (k = 0; k < 30 && op_enabled_o !== 1'b1; k++) @(negedge clk_i);
      chk("enabled after align", op_enabled_o, 32'd1);
      chk("travel resumed", travel_hold_o, 32'd0);
      chk("status enabled", status_word_o, 32'h8027);
      enable_req_i <= 1'b0;
      wait_cyc(2);
      chk("status off", status_word_o, 32'h0040);
      enable_req_i <= 1'b1;
      wait_cyc(2);
      chk("no second align", align_move_o, 32'd0);
      chk("enabled again", op_enabled_o, 32'd1);
      enable_req_i <= 1'b0;
      $display("test alignment done");
      do_reset();
      wr(24'h320303, 16'h0004);
      wr(24'h320200, 16'h0001);
      wait_cyc(2);
      chk("open before index", closed_loop_o, 32'd0);
      index_cmd <= 1'b1;
      @(posedge clk_i);
      index_cmd <= 1'b0;
      wait_cyc(12);
      chk("closed after index", closed_loop_o, 32'd1);
      chk("comm sel encoder", fb_sel_o.comm_sel, 32'd2);
      wr(24'h320200, 16'h0011);
      enable_req_i <= 1'b1;
      wait_cyc(2);
      chk("align by bit 4", align_move_o, 32'd1);
      $display("test index done");
      print_verdict();
   end
endmodule
`default_nettype wire
